// >>> design/gptc_pkg.sv
// Constants, types and register map of the timer counting core.
// Function
// [RULE1] 16-bit up/down counter, optional 32-bit extension.
// [RULE2] Period write immediate unless period buffering enabled.
// [RULE3] Counter advances every divider plus one cycles.
// [RULE4] Buffering copies divider into active copy at overflow.
// [RULE5] New divider applies only at next overflow event.
// [RULE6] Counter read returns live count; write replaces it.
// [RULE7] Overflow events on after reset; disable bit suppresses.
// [RULE8] Source bit limits overflow events to over/underflow.
// [RULE9] Run signal follows enable bit one cycle later.
// [RULE10] Upcount 0 to period, wrap, event, set flag.
// [RULE11] Copies reload only on enabled overflow events.
// [RULE12] Downcount period to 0, reload period, underflow event.
// [RULE13] Nonzero count-mode field selects up/down counting.
// [RULE14] Up/down: underflow at 1, overflow at period-1.
// [RULE15] Direction bit shows direction; read-only in up/down.
// [RULE16] Count-mode field gates compare flags by direction.
// [RULE17] Encoder: one channel clocks, other sets direction.
// [RULE18] Slave mode 001 counts channel one edges only.
// [RULE19] Slave mode 010 counts channel two edges only.
// [RULE20] Slave mode 011 counts edges of both channels.
// [RULE21] Channel one edge direction versus channel two level.
// [RULE22] Channel two edge direction versus channel one level.
// [RULE23] Software configures inputs before enabling encoder mode.
// [RULE24] Prescaler cycle counter restarts at each overflow event.
// [RULE25] Underflow sets the same overflow interrupt flag.
package gptc_pkg;

  localparam int unsigned NARROW_W = 16;
  localparam int unsigned WIDE_W   = 32;
  localparam int unsigned DIV_W    = 16;

  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_SWEVT  = 8'h08;
  localparam logic [7:0] OFF_COUNT  = 8'h0c;
  localparam logic [7:0] OFF_DIV    = 8'h10;
  localparam logic [7:0] OFF_PERIOD = 8'h14;
  localparam logic [7:0] OFF_SLAVE  = 8'h18;

  localparam int unsigned CTRL_W      = 8;
  localparam int unsigned POS_FLAG    = 0;
  localparam int unsigned POS_SWREQ   = 0;
  localparam int unsigned SLAVE_W     = 3;

  localparam logic [CTRL_W-1:0]  CTRL_RST  = 8'h00;
  localparam logic [DIV_W-1:0]   DIV_RST   = 16'h0000;
  localparam logic [WIDE_W-1:0]  PR_RST    = 32'h0000_0000;
  localparam logic [WIDE_W-1:0]  CNT_RST   = 32'h0000_0000;
  localparam logic [WIDE_W-1:0]  NARROW_MASK = 32'h0000_ffff;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {
    CM_ONEWAY  = 2'b00,
    CM_UD_DOWN = 2'b01,
    CM_UD_UP   = 2'b10,
    CM_UD_BOTH = 2'b11
  } gptc_cmode_e;

  typedef enum logic [2:0] {
    SM_INTERNAL = 3'b000,
    SM_ENC_A    = 3'b001,
    SM_ENC_B    = 3'b010,
    SM_ENC_C    = 3'b011
  } gptc_smode_e;

  // Control register layout, bit 0 is counter_run_bit.
  typedef struct packed {
    logic        width_extend_en;
    logic        period_buffer_en;
    gptc_cmode_e count_mode_field;
    logic        direction_bit;
    logic        ovf_source_sel;
    logic        ovf_event_disable;
    logic        counter_run_bit;
  } gptc_ctrl_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
  } gptc_dphase_s;

endpackage

// >>> design/gptc_enc.sv
// Quadrature decoder turning filtered channel levels into count steps.
`timescale 1ns/10ps
module gptc_enc
  import gptc_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic [1:0]         chan_level,
  input  gptc_pkg::gptc_smode_e   mode,
  output logic                    step,
  output logic                    down
);
  logic [1:0] prev_q;
  logic [1:0] edge_seen;
  logic [1:0] rise;
  logic       use1;
  logic       use2;
  logic       down1;
  logic       down2;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_chan
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
          prev_q[g] <= 1'b0;
        else
          prev_q[g] <= chan_level[g];
      end
      assign edge_seen[g] = chan_level[g] ^ prev_q[g];
      assign rise[g]      = chan_level[g] & ~prev_q[g];
    end
  endgenerate

  // Mode C prefers channel one if both channels move together.
  assign use1 = edge_seen[0] &
                ((mode == SM_ENC_A) | (mode == SM_ENC_C)); // see [RULE18] [RULE20]
  assign use2 = edge_seen[1] & ~use1 &
                ((mode == SM_ENC_B) | (mode == SM_ENC_C)); // see [RULE19] [RULE20]
  assign down1 = rise[0] ^ ~chan_level[1]; // see [RULE21]
  assign down2 = rise[1] ^ chan_level[0];  // see [RULE22]
  assign step  = use1 | use2;              // see [RULE17]
  assign down  = use1 ? down1 : down2;

endmodule

// >>> design/gptc_top.sv
// Timer counting core with prescaler, period copy and AHB-Lite registers.
`timescale 1ns/10ps
module gptc_top
  import gptc_pkg::*;
#(
  parameter bit EXT_OK = 1'b1
)
(
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire logic               chan1_filtered_edge,
  input  wire logic               chan2_filtered_edge,
  input  wire logic               slave_reset_req,
  output logic                    ovf_event,
  output logic                    ovf_irq_flag,
  output logic                    direction_bit,
  output logic                    run_signal_synced,
  output logic                    cmp_flag_allow,
  output logic [WIDE_W-1:0]       count_value
);

  gptc_ctrl_s          ctrl_q;
  gptc_ctrl_s          ctrl_wr;
  gptc_dphase_s        dp_q;
  gptc_dphase_s        dp_d;
  gptc_smode_e         smode_q;
  logic [DIV_W-1:0]    prescale_reg_q;
  logic [DIV_W-1:0]    div_act_q;
  logic [DIV_W-1:0]    presc_cnt_q;
  logic [DIV_W-1:0]    presc_cnt_d;
  logic [WIDE_W-1:0]   period_reg_q;
  logic [WIDE_W-1:0]   pr_act_q;
  logic [WIDE_W-1:0]   pr_act_d;
  logic [WIDE_W-1:0]   cnt_q;
  logic [WIDE_W-1:0]   cnt_d;
  logic [WIDE_W-1:0]   cnt_mask;
  logic [WIDE_W-1:0]   pr_eff;
  logic [WIDE_W-1:0]   pr_m1;
  logic                dir_q;
  logic                dir_d;
  logic                run_q;
  logic                flag_q;
  logic                evt_q;
  logic                addr_take;
  logic                wr_ctrl;
  logic                wr_status;
  logic                wr_swevt;
  logic                wr_count;
  logic                wr_div;
  logic                wr_period;
  logic                wr_slave;
  logic                sw_req;
  logic                ext_active;
  logic                enc_mode;
  logic                updown;
  logic                presc_tick;
  logic                enc_step;
  logic                enc_down;
  logic                step;
  logic                ovf_hw;
  logic                unf_hw;
  logic                hw_evt;
  logic                upd;
  logic                flag_clr;
  logic                dir_sw_ok;
  logic [31:0]         rd_mux;

  // Bus address phase is captured; the data phase does the access.
  assign addr_take = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign dp_d.valid = addr_take;
  assign dp_d.write = hwrite;
  assign dp_d.addr  = haddr[7:0];

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      dp_q <= '0;
    else
      dp_q <= dp_d;
  end

  // Zero wait states; every access is answered OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  // Writes land in the data phase, at the address captured before.
  assign wr_ctrl   = dp_q.valid & dp_q.write & (dp_q.addr == OFF_CTRL);
  assign wr_status = dp_q.valid & dp_q.write & (dp_q.addr == OFF_STATUS);
  assign wr_swevt  = dp_q.valid & dp_q.write & (dp_q.addr == OFF_SWEVT);
  assign wr_count  = dp_q.valid & dp_q.write & (dp_q.addr == OFF_COUNT);
  assign wr_div    = dp_q.valid & dp_q.write & (dp_q.addr == OFF_DIV);
  assign wr_period = dp_q.valid & dp_q.write & (dp_q.addr == OFF_PERIOD);
  assign wr_slave  = dp_q.valid & dp_q.write & (dp_q.addr == OFF_SLAVE);
  assign ctrl_wr   = gptc_ctrl_s'(hwdata[CTRL_W-1:0]);
  assign sw_req    = wr_swevt & hwdata[POS_SWREQ];
  // Writing zero to the flag bit clears it; writing one leaves it.
  assign flag_clr  = wr_status & ~hwdata[POS_FLAG];

  // Read data is taken from live state during the data phase.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (dp_q.addr)
      OFF_CTRL:
      begin
        rd_mux[CTRL_W-1:0] = ctrl_q;
        rd_mux[3]          = dir_q; // see [RULE15]
      end
      OFF_STATUS: rd_mux[POS_FLAG] = flag_q;
      OFF_COUNT:  rd_mux = cnt_q; // see [RULE6]
      OFF_DIV:    rd_mux[DIV_W-1:0] = prescale_reg_q;
      OFF_PERIOD: rd_mux = period_reg_q;
      OFF_SLAVE:  rd_mux[SLAVE_W-1:0] = smode_q;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // Outside a read data phase the bus sees zero.
  assign hrdata = (dp_q.valid & ~dp_q.write) ? rd_mux : 32'h0000_0000;

  // Software registers. A slave-mode code with no encoder meaning
  // leaves the counter on the internal clock.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q         <= gptc_ctrl_s'(CTRL_RST); // see [RULE7]
      prescale_reg_q <= DIV_RST;
      period_reg_q   <= PR_RST;
      smode_q        <= SM_INTERNAL;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= ctrl_wr;
      if (wr_div)
        prescale_reg_q <= hwdata[DIV_W-1:0];
      if (wr_period)
        period_reg_q <= hwdata;
      if (wr_slave)
        smode_q <= gptc_smode_e'(hwdata[SLAVE_W-1:0]);
    end
  end

  // The run signal trails the enable bit by one synchronising stage.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      run_q <= 1'b0;
    else
      run_q <= ctrl_q.counter_run_bit; // see [RULE9]
  end

  // Width extension only where the instance allows it.
  assign ext_active = EXT_OK & ctrl_q.width_extend_en;
  assign cnt_mask   = ext_active ? {WIDE_W{1'b1}} : NARROW_MASK; // see [RULE1]
  assign pr_eff     = pr_act_q & cnt_mask;
  // Up/down counting raises its overflow one step below the period.
  assign pr_m1      = pr_eff - 32'h0000_0001;

  assign enc_mode = (smode_q == SM_ENC_A) | (smode_q == SM_ENC_B) |
                    (smode_q == SM_ENC_C);
  assign updown   = ctrl_q.count_mode_field != CM_ONEWAY; // see [RULE13]

  // Encoder modes bypass the prescaler; each counted edge is one step.
  gptc_enc u_enc (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .chan_level ({chan2_filtered_edge, chan1_filtered_edge}),
    .mode       (smode_q),
    .step       (enc_step),
    .down       (enc_down)
  );

  // Prescaler divides by the active divider plus one.
  assign presc_tick = presc_cnt_q == div_act_q; // see [RULE3]

  // Update events clear the prescaler; otherwise it holds while stopped and in encoder modes.
  always_comb
  begin
    presc_cnt_d = presc_cnt_q;
    if (upd)
      presc_cnt_d = '0; // see [RULE24]
    else if (run_q & ~enc_mode)
      presc_cnt_d = presc_tick ? '0 : presc_cnt_q + 16'h0001;
  end

  // A zero period holds the counter still.
  assign step = run_q & (pr_eff != '0) &
                (enc_mode ? enc_step : presc_tick); // see [RULE17]

  // One-way and encoder counting wrap at the period ends, while
  // up/down counting turns round there.
  always_comb
  begin
    cnt_d  = cnt_q;
    dir_d  = dir_q;
    ovf_hw = 1'b0;
    unf_hw = 1'b0;
    if (step)
    begin
      if (enc_mode | ~updown)
      begin
        // The decoder sets the direction of each encoder step.
        if (enc_mode)
          dir_d = enc_down;
        if (!dir_d)
        begin
          if (cnt_q >= pr_eff)
          begin
            cnt_d  = '0;
            ovf_hw = 1'b1; // see [RULE10]
          end
          else
            cnt_d = cnt_q + 32'h0000_0001;
        end
        else if (cnt_q == '0)
        begin
          cnt_d  = pr_eff;
          unf_hw = 1'b1; // see [RULE12]
        end
        else
          cnt_d = cnt_q - 32'h0000_0001;
      end
      else if (dir_q)
      begin
        if (cnt_q <= 32'h0000_0001)
        begin
          cnt_d  = '0;
          unf_hw = 1'b1; // see [RULE14]
          dir_d  = 1'b0;
        end
        else
          cnt_d = cnt_q - 32'h0000_0001;
      end
      else if (cnt_q >= pr_m1)
      begin
        cnt_d  = pr_eff;
        ovf_hw = 1'b1; // see [RULE14]
        dir_d  = 1'b1;
      end
      else
        cnt_d = cnt_q + 32'h0000_0001;
    end
    // Software and slave-reset events restart the count.
    if (upd & ~hw_evt)
      cnt_d = (dir_d & ~updown) ? pr_eff : '0;
    if (wr_count)
      cnt_d = hwdata; // see [RULE6]
    cnt_d = cnt_d & cnt_mask;
  end

  // Hardware wraps qualify unless the disable bit is set; software and slave
  // requests only while the source bit is also clear.
  assign hw_evt = ovf_hw | unf_hw;
  assign upd = ~ctrl_q.ovf_event_disable & // see [RULE7]
               (hw_evt | (~ctrl_q.ovf_source_sel &
                (sw_req | slave_reset_req))); // see [RULE8]

  // Software may set direction only in one-way non-encoder counting.
  assign dir_sw_ok = wr_ctrl & ~enc_mode &
                     (ctrl_wr.count_mode_field == CM_ONEWAY);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q       <= CNT_RST;
      dir_q       <= 1'b0;
      presc_cnt_q <= '0;
    end
    else
    begin
      cnt_q       <= cnt_d;
      dir_q       <= dir_sw_ok ? ctrl_wr.direction_bit : dir_d; // see [RULE15]
      presc_cnt_q <= presc_cnt_d;
    end
  end

  // Active copies: period follows writes unless buffered.
  always_comb
  begin
    pr_act_d = pr_act_q;
    if (!ctrl_q.period_buffer_en)
      pr_act_d = period_reg_q; // see [RULE2]
    else if (upd)
      pr_act_d = period_reg_q; // see [RULE2] [RULE11]
  end

  // A new divider waits in its register until the next update event.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pr_act_q  <= PR_RST;
      div_act_q <= DIV_RST;
    end
    else
    begin
      pr_act_q <= pr_act_d;
      if (upd)
        div_act_q <= prescale_reg_q; // see [RULE4] [RULE5] [RULE11]
    end
  end

  // Flag is set by any update event; a set beats a clear.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_q <= 1'b0;
      evt_q  <= 1'b0;
    end
    else
    begin
      flag_q <= upd | (flag_q & ~flag_clr); // see [RULE10] [RULE25]
      evt_q  <= upd;
    end
  end

  // In up/down counting, compare flags are permitted only in the selected direction.
  always_comb
  begin
    case (ctrl_q.count_mode_field)
      CM_UD_DOWN: cmp_flag_allow = dir_q;  // see [RULE16]
      CM_UD_UP:   cmp_flag_allow = ~dir_q; // see [RULE16]
      CM_UD_BOTH: cmp_flag_allow = 1'b1;
      default:    cmp_flag_allow = 1'b1;
    endcase
  end

  assign ovf_event         = evt_q;
  assign ovf_irq_flag      = flag_q;
  assign direction_bit     = dir_q;
  assign run_signal_synced = run_q;
  assign count_value       = cnt_q;

endmodule

// >>> verif/gptc_props.sv
// Concurrent checks on the ports of the timer counting core.
`timescale 1ns/10ps
module gptc_props
  import gptc_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata,
  input wire logic              chan1_filtered_edge,
  input wire logic              chan2_filtered_edge,
  input wire logic              slave_reset_req,
  input wire logic              ovf_event,
  input wire logic              ovf_irq_flag,
  input wire logic              direction_bit,
  input wire logic              run_signal_synced,
  input wire logic              cmp_flag_allow,
  input wire logic [WIDE_W-1:0] count_value
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  gptc_dphase_s dph_q;
  logic [7:0]   ctl_q;
  logic [2:0]   sm_q;
  wire          take = hsel && hready && htrans == HTRANS_NONSEQ;
  wire          wr_ok = dph_q.valid && dph_q.write && hready;
  wire          lv_x = chan1_filtered_edge ^ chan2_filtered_edge;
  wire          run = run_signal_synced;

  // Shadows of the control and slave-mode fields, taken from bus writes.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dph_q <= '0;
      ctl_q <= '0;
      sm_q  <= '0;
    end
    else
    begin
      dph_q <= '{take, hwrite, haddr[7:0]};
      if (wr_ok && dph_q.addr == OFF_CTRL)
        ctl_q <= hwdata[7:0];
      if (wr_ok && dph_q.addr == OFF_SLAVE)
        sm_q <= hwdata[2:0];
    end
  end

  sequence s_wr(logic [7:0] a);
    wr_ok && dph_q.addr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    dph_q.valid && !dph_q.write && dph_q.addr == a;
  endsequence
  sequence s_run_on;
    !run ##1 run;
  endsequence

  run_delay_a: assert property (
    s_wr(OFF_CTRL) ##1 $rose(ctl_q[0]) |-> s_run_on)
    else $error("run signal not one cycle after enable");
  cnt_write_a: assert property (
    s_wr(OFF_COUNT) |=> count_value ==
      (ctl_q[7] ? $past(hwdata) : $past(hwdata) & NARROW_MASK))
    else $error("count write not applied");
  cnt_read_a: assert property (
    s_rd(OFF_COUNT) |-> hrdata == count_value && hresp == HRESP_OKAY)
    else $error("count read not live");
  ovf_flag_a: assert property (
    ovf_event |-> ovf_irq_flag)
    else $error("event without flag");
  sw_event_a: assert property (
    s_wr(OFF_SWEVT) ##0 (hwdata[0] && ctl_q[2:1] == 2'b00)
      |-> ##[1:3] ovf_event)
    else $error("software request gave no event");
  slave_event_a: assert property (
    slave_reset_req && ctl_q[2:1] == 2'b00 |-> ##[1:3] ovf_event)
    else $error("slave reset gave no event");
  ovf_off_a: assert property (
    ctl_q[1] && $past(ctl_q[1], 3) |-> !ovf_event)
    else $error("event while disabled");
  cmp_allow_a: assert property (
    ctl_q[5:4] != 2'b00 |-> cmp_flag_allow ==
      (ctl_q[5] && ctl_q[4] || ctl_q[4] == direction_bit))
    else $error("compare gate wrong");
  enc_ch1_a: assert property (
    run && sm_q inside {SM_ENC_A, SM_ENC_C} && $changed(chan1_filtered_edge)
      |=> count_value - $past(count_value) ==
        ($past(lv_x) ? 32'h1 : 32'hffff_ffff))
    else $error("channel one step wrong");
  enc_ch2_a: assert property (
    run && (sm_q == SM_ENC_B || sm_q == SM_ENC_C &&
      $stable(chan1_filtered_edge)) && $changed(chan2_filtered_edge)
      |=> count_value - $past(count_value) ==
        ($past(lv_x) ? 32'hffff_ffff : 32'h1))
    else $error("channel two step wrong");
  enc_still_a: assert property (
    run && sm_q == SM_ENC_A && $changed(chan2_filtered_edge) &&
      $stable(chan1_filtered_edge) |=> $stable(count_value))
    else $error("count moved on channel two");
endmodule

bind gptc_top gptc_props u_props (.clk_sys, .rst_n, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hresp, .hrdata,
  .chan1_filtered_edge, .chan2_filtered_edge, .slave_reset_req,
  .ovf_event, .ovf_irq_flag, .direction_bit, .run_signal_synced,
  .cmp_flag_allow, .count_value);

// >>> verif/gptc_quad_src.sv
// Quadrature encoder source driving the two filtered channel levels.
`timescale 1ns/10ps
module gptc_quad_src
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic step,
  input  wire logic rev,
  output logic      chan1,
  output logic      chan2
);
  logic [1:0] ph_q;
  logic [1:0] ph_d;
  // Gray order on {chan2, chan1}; only one channel moves per step.
  assign ph_d  = rev ? {~ph_q[0], ph_q[1]}
                     : {ph_q[0], ~ph_q[1]};
  assign chan1 = ph_q[0];
  assign chan2 = ph_q[1];
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ph_q <= 2'b00;
    else if (step)
      ph_q <= ph_d;
  end
endmodule

// >>> verif/gptc_top_tb.sv
// Self-checking bench for the timer counting core.
`timescale 1ns/10ps
module gptc_top_tb;
  import gptc_pkg::*;
  localparam logic [7:0]  CFG [6] = '{8'h01, 8'h09, 8'h11, 8'h21, 8'h31, 8'h05};
  localparam logic [31:0] DV [6]  = '{3, 1, 0, 0, 0, 0};
  localparam logic [31:0] PR [6]  = '{5, 5, 4, 4, 4, 3};
  localparam logic [31:0] IV [6]  = '{24, 12, 4, 4, 4, 4};
  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b0;
  logic [31:0]       haddr = '0;
  logic [1:0]        htrans = 2'b00;
  logic              hwrite = 1'b0;
  logic [31:0]       hwdata = '0;
  logic              slave_reset_req = 1'b0;
  logic              step = 1'b0;
  logic              rev = 1'b0;
  logic              rd_ph = 1'b0;
  logic [31:0]       seed = 32'h4c265241;
  logic [31:0]       exp_q[$];
  int                n_fail = 0;
  int                checked = 0;
  wire               hready;
  wire               hresp;
  wire [31:0]        hrdata;
  wire               ch1;
  wire               ch2;
  wire               ovf_event;
  wire [WIDE_W-1:0]  count_value;

  always #4 clk_sys = ~clk_sys;

  gptc_top DUT (.clk_sys, .rst_n, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata,
    .chan1_filtered_edge(ch1), .chan2_filtered_edge(ch2), .slave_reset_req,
    .ovf_event, .ovf_irq_flag(), .direction_bit(), .run_signal_synced(),
    .cmp_flag_allow(), .count_value);
  gptc_quad_src u_src (.clk_sys, .rst_n, .step, .rev, .chan1(ch1),
    .chan2(ch2));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wait_evt(output int n);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (ovf_event !== 1'b1 && n < 300);
  endtask

  // Inputs and mode are set up while stopped, then the run bit goes on.
  task automatic setup(input logic [7:0] c, input logic [31:0] dv, pr, sm);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_DIV, dv);
    wr(OFF_PERIOD, pr);
    wr(OFF_SLAVE, sm);
    wr(OFF_CTRL, {24'h0, c});
    wr(OFF_SWEVT, 32'h1);
  endtask

  always @(posedge clk_sys)
  begin
    if (rd_ph)
      check("hrdata", hrdata, exp_q.pop_front());
    rd_ph <= hready && htrans == HTRANS_NONSEQ && !hwrite;
  end

  initial
  begin
    int n;
    logic [31:0] v;
    logic [31:0] k;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(OFF_CTRL, {24'h0, CTRL_RST});
    rd(OFF_COUNT, CNT_RST);
    wr(8'h1c, rnd());
    rd(8'h1c, 32'h0);
    v = rnd();
    wr(OFF_COUNT, v);
    rd(OFF_COUNT, v & NARROW_MASK);
    wr(OFF_CTRL, 32'h80);
    wr(OFF_COUNT, v);
    rd(OFF_COUNT, v);
    for (int i = 0; i < 6; i++)
    begin
      setup(CFG[i], DV[i], PR[i], 32'h0);
      wait_evt(n);
      wait_evt(n);
      wait_evt(n);
      check("interval", 32'(n), IV[i]);
      wait_evt(n);
      check("interval", 32'(n), IV[i]);
    end
    setup(8'h41, 32'h0, 32'h9, 32'h0);
    wait_evt(n);
    wait_evt(n);
    wr(OFF_PERIOD, 32'h3);
    wait_evt(n);
    check("buffered", 32'(n), 32'h8);
    wait_evt(n);
    check("buffered", 32'(n), 32'h4);
    wr(OFF_DIV, 32'h1);
    wait_evt(n);
    check("divider", 32'(n), 32'h2);
    wait_evt(n);
    check("divider", 32'(n), 32'h8);
    wr(OFF_CTRL, 32'h0);
    rd(OFF_STATUS, 32'h1);
    wr(OFF_STATUS, 32'h0);
    rd(OFF_STATUS, 32'h0);
    setup(8'h03, 32'h0, 32'h3, 32'h0);
    repeat (40) @(posedge clk_sys);
    rd(OFF_STATUS, 32'h0);
    setup(8'h01, 32'h0, 32'd50, 32'h0);
    repeat (10) @(posedge clk_sys);
    slave_reset_req <= 1'b1;
    @(posedge clk_sys);
    slave_reset_req <= 1'b0;
    wait_evt(n);
    check("slave", {31'h0, n <= 3}, 32'h1);
    for (int m = 1; m < 4; m++)
      for (int r = 0; r < 2; r++)
      begin
        setup(8'h01, 32'h0, 32'd1000, m);
        v = (rnd() & 32'h01ff) + 32'h10;
        k = (m == 3) ? 32'h4 : 32'h2;
        wr(OFF_COUNT, v);
        rev <= r[0];
        repeat (4)
        begin
          step <= 1'b1;
          @(posedge clk_sys);
          step <= 1'b0;
          repeat (2) @(posedge clk_sys);
        end
        rd(OFF_COUNT, r[0] ? v - k : v + k);
        rd(OFF_CTRL, {28'h0, r[0], 3'b001});
      end
    @(posedge clk_sys);
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    complete_run();
  end
endmodule
